// [ect_consts.vh]
// constants for the 8-bit edge capture timer
`ifndef ECT_CONSTS_VH
`define ECT_CONSTS_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ECT_IDX_W 16
`define ECT_IDX_MODE 16'hffbc
`define ECT_IDX_FALL_CAP 16'hffbd
`define ECT_IDX_RISE_CAP 16'hffbe
`define ECT_IDX_CLK_STOP 16'hfffa
`define ECT_IDX_PORT_MODE 16'hffe0
`define ECT_IDX_IRQ_REQ 16'hffe1
`define ECT_IDX_IRQ_EN 16'hffe2

// ----------------------------------------------------------------------------
// bus shape
// ----------------------------------------------------------------------------
`define ECT_ADDR_W 18
`define ECT_DATA_W 32
`define ECT_REG_W 8

// ----------------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------------
`define ECT_MODE_OVF_HIGH 7
`define ECT_MODE_OVF_LOW 6
`define ECT_MODE_OVF_IE 5
`define ECT_MODE_IRQ_EDGE 4
`define ECT_MODE_CCLR_HI 3
`define ECT_MODE_CCLR_LO 2
`define ECT_MODE_CKS_HI 1
`define ECT_MODE_CKS_LO 0
`define ECT_MODE_CTRL_MASK 8'h3f

// clock select codes
`define ECT_CKS_DIV64 2'h0
`define ECT_CKS_DIV32 2'h1
`define ECT_CKS_DIV2 2'h2
`define ECT_CKS_WATCH4 2'h3

// counter clear codes
`define ECT_CCLR_NONE 2'h0
`define ECT_CCLR_FALL 2'h1
`define ECT_CCLR_RISE 2'h2
`define ECT_CCLR_BOTH 2'h3

// ----------------------------------------------------------------------------
// other fields
// ----------------------------------------------------------------------------
`define ECT_STOP_TIMER_BIT 3
`define ECT_STOP_WR_MASK 8'h3f
`define ECT_STOP_FIXED_ONES 8'hc0
`define ECT_PORT_CAPTURE_BIT 0
`define ECT_IRQ_TIMER_BIT 0

// ----------------------------------------------------------------------------
// reset values and prescaler terminal counts
// ----------------------------------------------------------------------------
`define ECT_MODE_RST 8'h00
`define ECT_CAP_RST 8'h00
`define ECT_COUNT_RST 8'h00
`define ECT_COUNT_MAX 8'hff
`define ECT_CLK_STOP_RST 8'hff
`define ECT_PRESC_W 6
`define ECT_PRESC_RST 6'h00
`define ECT_PRESC_END64 6'h3f
`define ECT_PRESC_END32 5'h1f
`define ECT_WATCH_DIV_W 2
`define ECT_WATCH_DIV_END 2'h3

`endif

// [ect_timer.v]
// 8-bit edge capture timer with APB register access
//
// Overview of operation
// R1 - 8-bit up-counter ticks on selected divided clock
// R2 - clock select: /64, /32, /2, watch/4
// R3 - capture mode bit one, interval mode zero
// R4 - mode change edges handled like real edges
// R5 - capture edges may clear the counter
// R6 - clear field: none, fall, rise, both
// R7 - enabled wrap sets shared timer request flag
// R8 - counter not bus visible, reset to zero
// R9 - falling edge captures count, may request irq
// R10 - rising edge captures count, may request irq
// R11 - capture registers read-only, reset to zero
// R12 - source holds pulse two system clocks
// R13 - wrap while input high sets high flag
// R14 - wrap while low or interval sets low flag
// R15 - flags cleared by read-one then write-zero
// R16 - mode bit five enables overflow requests
// R17 - mode register eight bits, resets zero
// R18 - one selected edge plus overflow share request
// R19 - low power counting only on watch source
// R20 - standby bit zero stops the timer
// R21 - capture takes pre-clear count value
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ect_consts.vh"

module ect_timer (
  input wire CLK_SYS_I,
  input wire NRST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [`ECT_ADDR_W-1:0] PADDR_I,
  input wire [`ECT_DATA_W-1:0] PWDATA_I,
  output reg [`ECT_DATA_W-1:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  input wire CAPTURE_PIN_I,
  input wire WATCH_CLK_I,
  input wire LOW_POWER_I,
  output wire TIMER_IRQ_O
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [`ECT_REG_W-1:0] timer_mode_control;
  reg [`ECT_REG_W-1:0] falling_edge_capture;
  reg [`ECT_REG_W-1:0] rising_edge_capture;
  reg [`ECT_REG_W-1:0] module_clock_stop;
  reg capture_pin_select;
  reg timer_irq_request_flag;
  reg timer_irq_enable;
  reg [`ECT_REG_W-1:0] count_value;
  reg [`ECT_PRESC_W-1:0] prescale;
  reg [`ECT_WATCH_DIV_W-1:0] watch_div;
  reg irq_armed;

  // edge detector history
  reg cap_prev;
  reg watch_prev;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  wire [`ECT_IDX_W-1:0] idx = PADDR_I[`ECT_ADDR_W-1:2];
  wire hit_mode = (idx == `ECT_IDX_MODE);
  wire hit_fall = (idx == `ECT_IDX_FALL_CAP);
  wire hit_rise = (idx == `ECT_IDX_RISE_CAP);
  wire hit_stop = (idx == `ECT_IDX_CLK_STOP);
  wire hit_port = (idx == `ECT_IDX_PORT_MODE);
  wire hit_req = (idx == `ECT_IDX_IRQ_REQ);
  wire hit_en = (idx == `ECT_IDX_IRQ_EN);
  wire hit_any = hit_mode | hit_fall | hit_rise | hit_stop |
                 hit_port | hit_req | hit_en;
  wire setup_ph = PSEL_I & ~PENABLE_I;
  wire access_ph = PSEL_I & PENABLE_I;
  wire wr_ok = access_ph & PWRITE_I & hit_any;
  wire rd_ok = access_ph & ~PWRITE_I & hit_any;
  wire [`ECT_REG_W-1:0] wdat = PWDATA_I[`ECT_REG_W-1:0];

  // zero wait states; unmapped index answers with an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access_ph & ~hit_any;

  // --------------------------------------------------------------------------
  // field views
  // --------------------------------------------------------------------------
  wire [1:0] clk_sel = {timer_mode_control[`ECT_MODE_CKS_HI],
                        timer_mode_control[`ECT_MODE_CKS_LO]};
  wire [1:0] clr_sel = {timer_mode_control[`ECT_MODE_CCLR_HI],
                        timer_mode_control[`ECT_MODE_CCLR_LO]};
  wire ovf_ie = timer_mode_control[`ECT_MODE_OVF_IE];
  wire irq_edge = timer_mode_control[`ECT_MODE_IRQ_EDGE];
  wire running = module_clock_stop[`ECT_STOP_TIMER_BIT]; // [R20]

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  // index 0 capture pin, index 1 watch clock
  wire [1:0] async_in = {WATCH_CLK_I, CAPTURE_PIN_I};
  wire [1:0] sync_out;

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_sync
      // stage one feeds only stage two
      reg meta;
      reg held;
      always @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
          meta <= 1'b0;
          held <= 1'b0;
        end else begin
          meta <= async_in[s];
          held <= meta;
        end
      end
      assign sync_out[s] = held;
    end
  endgenerate

  wire cap_sync = sync_out[0];
  wire watch_sync = sync_out[1];

  // watch edge detector starts at the pin's idle low level
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      watch_prev <= 1'b0;
    end else begin
      watch_prev <= watch_sync;
    end
  end

  // --------------------------------------------------------------------------
  // clock sources
  // --------------------------------------------------------------------------
  wire watch_rise = watch_sync & ~watch_prev;
  wire tick64 = (prescale == `ECT_PRESC_END64);
  wire tick32 = (prescale[4:0] == `ECT_PRESC_END32);
  wire tick2 = prescale[0];
  wire tick_w4 = watch_rise & (watch_div == `ECT_WATCH_DIV_END);

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prescale <= `ECT_PRESC_RST;
      watch_div <= {`ECT_WATCH_DIV_W{1'b0}};
    end else if (running) begin
      // free-running; a select change may shorten the first tick
      prescale <= prescale + 1'b1;
      if (watch_rise) begin
        watch_div <= watch_div + 1'b1;
      end
    end
  end

  reg sel_tick;
  always @* begin
    case (clk_sel) // [R2]
      `ECT_CKS_DIV64: sel_tick = tick64;
      `ECT_CKS_DIV32: sel_tick = tick32;
      `ECT_CKS_DIV2: sel_tick = tick2;
      `ECT_CKS_WATCH4: sel_tick = tick_w4;
      default: sel_tick = 1'b0;
    endcase
  end

  // low power keeps only the watch source alive
  wire low_power_ok = ~LOW_POWER_I | (clk_sel == `ECT_CKS_WATCH4); // [R19]
  wire count_tick = running & low_power_ok & sel_tick; // [R1]

  // --------------------------------------------------------------------------
  // capture edge detection
  // --------------------------------------------------------------------------
  // gated level: leaving or entering capture mode can itself make an edge
  wire cap_level = capture_pin_select & cap_sync; // [R3]

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cap_prev <= 1'b0;
    end else if (running) begin
      // standby freezes the history; a change while stopped shows on wake
      cap_prev <= cap_level;
    end
  end

  // edges from a mode switch are handled exactly like pin edges
  wire edge_rise = running & cap_level & ~cap_prev; // [R4]
  wire edge_fall = running & ~cap_level & cap_prev; // [R4]

  reg clr_hit;
  always @* begin
    case (clr_sel) // [R6]
      `ECT_CCLR_NONE: clr_hit = 1'b0;
      `ECT_CCLR_FALL: clr_hit = edge_fall;
      `ECT_CCLR_RISE: clr_hit = edge_rise;
      `ECT_CCLR_BOTH: clr_hit = edge_rise | edge_fall;
      default: clr_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------------
  // a clear beats a tick in the same cycle, so no wrap is seen then
  wire wrap = count_tick & ~clr_hit & (count_value == `ECT_COUNT_MAX);
  wire wrap_high = wrap & capture_pin_select & cap_sync; // [R13]
  wire wrap_low = wrap & ~(capture_pin_select & cap_sync); // [R14]

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      count_value <= `ECT_COUNT_RST; // [R8]
    end else if (clr_hit) begin
      count_value <= `ECT_COUNT_RST; // [R5]
    end else if (count_tick) begin
      count_value <= count_value + 1'b1; // [R1]
    end
  end

  // --------------------------------------------------------------------------
  // capture registers
  // --------------------------------------------------------------------------
  // sampled before the clear lands, so they hold the pre-clear count
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      falling_edge_capture <= `ECT_CAP_RST; // [R11]
      rising_edge_capture <= `ECT_CAP_RST; // [R11]
    end else begin
      if (edge_fall) begin
        falling_edge_capture <= count_value; // [R9] [R21]
      end
      if (edge_rise) begin
        rising_edge_capture <= count_value; // [R10] [R21]
      end
    end
  end

  // --------------------------------------------------------------------------
  // mode register and overflow flags
  // --------------------------------------------------------------------------
  wire mode_wr = wr_ok & hit_mode;
  wire mode_rd = rd_ok & hit_mode;
  // index 1 is the high-level flag, index 0 the low-level flag
  wire [1:0] ovf_cur = {timer_mode_control[`ECT_MODE_OVF_HIGH],
                        timer_mode_control[`ECT_MODE_OVF_LOW]};
  wire [1:0] ovf_seen = {PRDATA_O[`ECT_MODE_OVF_HIGH], PRDATA_O[`ECT_MODE_OVF_LOW]};
  wire [1:0] ovf_wdat = {wdat[`ECT_MODE_OVF_HIGH], wdat[`ECT_MODE_OVF_LOW]};
  wire [1:0] ovf_event = {wrap_high, wrap_low};
  wire [1:0] next_ovf;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ovf
      // armed from the word the read returned, not the live flag,
      // so a flag set between setup and access is never lost
      reg armed;
      wire flag_clr = mode_wr & armed & ~ovf_wdat[g]; // [R15]

      // hardware set wins over a software clear; a one never sets
      assign next_ovf[g] = ovf_event[g] | (ovf_cur[g] & ~flag_clr); // [R13] [R14] [R15]

      always @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
          armed <= 1'b0;
        end else if (mode_rd) begin
          armed <= ovf_seen[g];
        end else if (mode_wr) begin
          armed <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      timer_mode_control <= `ECT_MODE_RST; // [R17]
    end else begin
      timer_mode_control[`ECT_MODE_OVF_HIGH] <= next_ovf[1];
      timer_mode_control[`ECT_MODE_OVF_LOW] <= next_ovf[0];
      if (mode_wr) begin
        timer_mode_control[`ECT_MODE_OVF_IE:0] <= wdat[`ECT_MODE_OVF_IE:0]; // [R17]
      end
    end
  end

  // --------------------------------------------------------------------------
  // module stop and port mode registers
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      module_clock_stop <= `ECT_CLK_STOP_RST; // [R20]
      capture_pin_select <= 1'b0;
    end else begin
      if (wr_ok & hit_stop) begin
        // unused upper bits always read as one
        module_clock_stop <= (wdat & `ECT_STOP_WR_MASK) | `ECT_STOP_FIXED_ONES;
      end
      if (wr_ok & hit_port) begin
        capture_pin_select <= wdat[`ECT_PORT_CAPTURE_BIT]; // [R3]
      end
    end
  end

  // --------------------------------------------------------------------------
  // shared timer request flag
  // --------------------------------------------------------------------------
  // one capture polarity plus the overflow feed a single flag
  wire cap_req = irq_edge ? edge_fall : edge_rise; // [R18] [R9] [R10]
  wire ovf_req = ovf_ie & wrap; // [R7] [R16]
  wire req_set = cap_req | ovf_req; // [R18]
  wire req_wr = wr_ok & hit_req;

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      timer_irq_request_flag <= 1'b0;
      timer_irq_enable <= 1'b0;
      irq_armed <= 1'b0;
    end else begin
      if (req_set) begin
        timer_irq_request_flag <= 1'b1; // [R7]
      end else if (req_wr & irq_armed & ~wdat[`ECT_IRQ_TIMER_BIT]) begin
        timer_irq_request_flag <= 1'b0; // [R15]
      end
      // armed from the word the read returned
      if (rd_ok & hit_req) begin
        irq_armed <= PRDATA_O[`ECT_IRQ_TIMER_BIT];
      end else if (req_wr) begin
        irq_armed <= 1'b0;
      end
      if (wr_ok & hit_en) begin
        timer_irq_enable <= wdat[`ECT_IRQ_TIMER_BIT];
      end
    end
  end

  assign TIMER_IRQ_O = timer_irq_request_flag & timer_irq_enable; // [R7]

  // --------------------------------------------------------------------------
  // read data, captured in the setup phase
  // --------------------------------------------------------------------------
  reg [`ECT_REG_W-1:0] rd_mux;
  always @* begin
    rd_mux = {`ECT_REG_W{1'b0}};
    if (hit_mode) begin
      rd_mux = timer_mode_control;
    end else if (hit_fall) begin
      rd_mux = falling_edge_capture;
    end else if (hit_rise) begin
      rd_mux = rising_edge_capture;
    end else if (hit_stop) begin
      rd_mux = module_clock_stop;
    end else if (hit_port) begin
      rd_mux = {{(`ECT_REG_W-1){1'b0}}, capture_pin_select};
    end else if (hit_req) begin
      rd_mux = {{(`ECT_REG_W-1){1'b0}}, timer_irq_request_flag};
    end else if (hit_en) begin
      rd_mux = {{(`ECT_REG_W-1){1'b0}}, timer_irq_enable};
    end
  end

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PRDATA_O <= {`ECT_DATA_W{1'b0}};
    end else if (setup_ph & ~PWRITE_I) begin
      // held through the access phase for the master to sample
      PRDATA_O <= {{(`ECT_DATA_W-`ECT_REG_W){1'b0}}, rd_mux};
    end
  end

endmodule // ect_timer
`default_nettype wire

// [ect_timer_sva.sv]
// port-level assertions for the edge capture timer
`timescale 1ns/1ps
`default_nettype none
`include "ect_consts.vh"
module ect_timer_sva (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`ECT_ADDR_W-1:0] PADDR_I,
  input wire logic [`ECT_DATA_W-1:0] PWDATA_I,
  input wire logic [`ECT_DATA_W-1:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire logic TIMER_IRQ_O
);
  // ---------------------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------------------
  wire [15:0] idx = PADDR_I[17:2];
  wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  wire mapped = idx == `ECT_IDX_MODE || idx == `ECT_IDX_FALL_CAP || idx == `ECT_IDX_RISE_CAP ||
    idx == `ECT_IDX_CLK_STOP || idx == `ECT_IDX_PORT_MODE || idx == `ECT_IDX_IRQ_REQ ||
    idx == `ECT_IDX_IRQ_EN;
  reg [5:0] ctrl;
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) ctrl <= 6'h00;
    else if (wr_acc && idx == `ECT_IDX_MODE) ctrl <= PWDATA_I[5:0];
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  sequence s_acc; PSEL_I && PENABLE_I; endsequence
  sequence s_rd_setup; PSEL_I && !PENABLE_I && !PWRITE_I; endsequence
  property p_err_phase; PSLVERR_O |-> PSEL_I && PENABLE_I; endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("slave error outside access phase");
  property p_err_unmapped; s_acc |-> PSLVERR_O == !mapped; endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("slave error does not match address decode");
  property p_rd_unmapped; s_rd_setup ##0 !mapped |=> PRDATA_O == 32'h0; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read returned data");
  property p_upper; PRDATA_O[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("read data upper bits not zero");
  property p_stop; s_rd_setup ##0 idx == `ECT_IDX_CLK_STOP |=> PRDATA_O[7:6] == 2'h3; endproperty
  a_stop: assert property (p_stop)
    else $error("clock stop fixed bits not one");
  property p_mode; s_rd_setup ##0 idx == `ECT_IDX_MODE |=> PRDATA_O[5:0] == ctrl; endproperty
  a_mode: assert property (p_mode)
    else $error("mode control bits differ from last write");
  property p_irq_clear; $fell(TIMER_IRQ_O) |-> $past(wr_acc); endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("request dropped without a write");
  property p_hold; !(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O); endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed outside read setup");
endmodule // ect_timer_sva
bind ect_timer ect_timer_sva i_sva (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .TIMER_IRQ_O(TIMER_IRQ_O));
`default_nettype wire

// [ect_pulse_src.sv]
// capture pin source model
`timescale 1ns/1ps
`default_nettype none
module ect_pulse_src (
  input wire logic clk_i,
  output var logic pin_o
);
  initial pin_o = 1'b0;
  // new level held long enough to pass the synchroniser
  task automatic set(input logic lvl);
    @(posedge clk_i);
    pin_o <= lvl;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // ect_pulse_src
`default_nettype wire

// [test_edge_capture_timer8.sv]
// self-checking bench for the edge capture timer
`timescale 1ns/1ps
`default_nettype none
`include "ect_consts.vh"
module test_edge_capture_timer8;
  logic clk = 1'b0;
  logic nrst;
  logic psel;
  logic pen;
  logic pwr;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic watch;
  logic lp;
  logic errs;
  logic [7:0] v, f, r, p;
  wire [31:0] prdata;
  wire pready, pslverr, pin, irq;
  int err_total = 0;
  int checks_done = 0;
  int cks, div, lo, hi;
  always #10 clk = ~clk;
  always #55 watch = ~watch;
  ect_timer i_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CAPTURE_PIN_I(pin), .WATCH_CLK_I(watch), .LOW_POWER_I(lp),
    .TIMER_IRQ_O(irq));
  ect_pulse_src i_src (.clk_i(clk), .pin_o(pin));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    v = prdata[7:0];
    errs = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic clr_req;
    apb(1'b0, `ECT_IDX_IRQ_REQ, 8'h00);
    apb(1'b1, `ECT_IDX_IRQ_REQ, 8'h00);
    // let the cleared flag settle before anyone looks at it
    @(posedge clk);
  endtask
  // rise, fall, rise with w+9 cycles between edges
  task automatic meas(input logic [7:0] mode, input int w);
    apb(1'b1, `ECT_IDX_MODE, mode);
    i_src.set(1'b1);
    repeat (w) @(posedge clk);
    i_src.set(1'b0);
    repeat (w) @(posedge clk);
    i_src.set(1'b1);
    apb(1'b0, `ECT_IDX_FALL_CAP, 8'h00);
    f = v;
    apb(1'b0, `ECT_IDX_RISE_CAP, 8'h00);
    r = v;
    i_src.set(1'b0);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    nrst <= 1'b0;
    psel <= 1'b0;
    pen <= 1'b0;
    pwr <= 1'b0;
    paddr <= 18'h0;
    pwdata <= 32'h0;
    watch <= 1'b0;
    lp <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    check("mode rst", v, 8'h00);
    apb(1'b0, `ECT_IDX_FALL_CAP, 8'h00);
    check("fall rst", v, 8'h00);
    apb(1'b0, `ECT_IDX_RISE_CAP, 8'h00);
    check("rise rst", v, 8'h00);
    apb(1'b0, `ECT_IDX_CLK_STOP, 8'h00);
    check("stop rst", v, 8'hff);
    apb(1'b1, `ECT_IDX_FALL_CAP, 8'h5a);
    apb(1'b0, `ECT_IDX_FALL_CAP, 8'h00);
    check("fall wr", v, 8'h00);
    apb(1'b1, `ECT_IDX_MODE, 8'hff);
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    check("mode wr", v, 8'h3f);
    apb(1'b0, 16'h0000, 8'h00);
    check("unmapped", {errs, v[6:0]}, 8'h80);
    apb(1'b1, `ECT_IDX_PORT_MODE, 8'h01);
    apb(1'b1, `ECT_IDX_IRQ_EN, 8'h01);
    apb(1'b1, `ECT_IDX_MODE, 8'h12);
    i_src.set(1'b1);
    check("irq rise", {7'h0, irq}, 8'h00);
    i_src.set(1'b0);
    check("irq fall", {7'h0, irq}, 8'h01);
    clr_req;
    check("irq clr", {7'h0, irq}, 8'h00);
    apb(1'b1, `ECT_IDX_MODE, 8'h02);
    i_src.set(1'b1);
    check("irq rise", {7'h0, irq}, 8'h01);
    i_src.set(1'b0);
    for (int i = 0; i < 6; i++) begin
      cks = i < 4 ? i : i - 2;
      div = cks == 0 ? 64 : cks == 1 ? 32 : cks == 2 ? 2 : 22;
      lo = i == 4 ? 0 : 8;
      hi = i == 4 ? 0 : 11;
      lp <= i > 3;
      meas({6'h02, cks[1:0]}, 10 * div - 8);
      check("tick", 8'(f >= lo && f <= hi), 8'h01);
    end
    lp <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      meas({4'h0, c[1:0], 2'h2}, 12);
      if (c[1]) check("fall clr", 8'(f >= 8 && f <= 11), 8'h01);
      if (c[0]) check("rise clr", 8'(r >= 8 && r <= 11), 8'h01);
    end
    apb(1'b1, `ECT_IDX_PORT_MODE, 8'h00);
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    apb(1'b1, `ECT_IDX_MODE, 8'h22);
    clr_req;
    do @(posedge clk); while (irq !== 1'b1);
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    check("ovf low", v, 8'h62);
    apb(1'b1, `ECT_IDX_MODE, 8'h22);
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    check("ovf clr", v, 8'h22);
    apb(1'b1, `ECT_IDX_MODE, 8'he2);
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    check("no set", v, 8'h22);
    i_src.set(1'b1);
    apb(1'b1, `ECT_IDX_PORT_MODE, 8'h01);
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    apb(1'b1, `ECT_IDX_MODE, 8'h22);
    clr_req;
    do @(posedge clk); while (irq !== 1'b1);
    apb(1'b0, `ECT_IDX_MODE, 8'h00);
    check("ovf high", v, 8'ha2);
    i_src.set(1'b0);
    apb(1'b1, `ECT_IDX_CLK_STOP, 8'hf7);
    apb(1'b0, `ECT_IDX_CLK_STOP, 8'h00);
    check("stop wr", v, 8'hf7);
    apb(1'b0, `ECT_IDX_FALL_CAP, 8'h00);
    p = v;
    meas(8'h0a, 12);
    check("frozen", f, p);
    apb(1'b1, `ECT_IDX_CLK_STOP, 8'hff);
    results;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    results;
  end
endmodule // test_edge_capture_timer8
`default_nettype wire
